//--- nsp_array_model.sv
// Memory array stand-in that answers each launched operation after a delay.
`timescale 1ns/10ps
`default_nettype none
module nsp_array_model (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Operation handshake with the controller.
	input wire logic op,
	input wire logic slow,
	output logic done_q
);
	logic [4:0] cnt_q;

	// A slow answer keeps the controller busy for a while, so that a
	// controller which drops busy early is caught by the next command.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= 5'h00;
			done_q <= 1'h0;
		end else begin
			done_q <= (cnt_q == 5'h01);
			if (op) begin
				cnt_q <= slow ? 5'h14 : 5'h01;
			end else if (cnt_q != 5'h00) begin
				cnt_q <= cnt_q - 5'h01;
			end
		end
	end
endmodule
`default_nettype wire

//--- nsp_pkg.sv
// Constants, types and register map for the flash section write protection.
// Overview of operation
// R1: Sections count 256-byte blocks; loader lies below loader_end_fuse*256.
// R2: A zero loader_end_fuse makes all flash the loader section.
// R3: code_end_fuse zero, loader end nonzero: code section runs to flash end.
// R4: code_end_fuse not above loader end: no code section, data to flash end.
// R5: code_end_fuse above loader end: code below its boundary, data above it.
// R6: A fuse whose boundary is past the last flash address uses its default.
// R7: Loader code may write the program code and program data sections.
// R8: Program code may write the program data section.
// R9: Program data code may write neither flash nor EEPROM.
// R10: No processor code may ever write the loader section.
// R11: An effective loader lock blocks reads and fetches of loader flash.
// R12: Lock is set only from loader code and acts once execution leaves it.
// R13: A set program_code_write_guard refuses any update of the code section; the code applies it to processor commands only, not to the debug link.
// R14: Flash is written or erased only in whole pages.
// R15: EEPROM page operations touch only bytes marked as updated.
// R16: Writing a byte into the page buffer marks it as updated.
// R17: User row is one more EEPROM page and survives a chip erase.
// R18: The debug link may write the user row even on a locked device.
// R19: Vectors start the code section; vector_table_select moves them to 0.
// R20: Chip erase ignores the loader lock and the write guard.
// R21: A boundary address belongs to the upper section.
// R22: A write or erase that breaks protection is discarded, memory unchanged.
package nsp_pkg;
	localparam int ADDR_W = 15;
	localparam int BLK_W = 7;
	localparam int PAGE_BYTES = 64;
	localparam int OFS_W = 6;
	localparam int PAGE_W = 9;
	localparam int REG_AW = 8;
	localparam logic [7:0] LAST_BLOCK = 8'h7f;
	localparam logic [7:0] LOADER_END_DEFAULT = 8'h00;
	localparam logic [7:0] CODE_END_DEFAULT = 8'h00;
	localparam logic [7:0] BUF_ERASED = 8'hff;
	// Register offsets.
	localparam logic [REG_AW-1:0] REG_CMD = 8'h00;
	localparam logic [REG_AW-1:0] REG_CTRL = 8'h04;
	localparam logic [REG_AW-1:0] REG_STATUS = 8'h08;
	localparam logic [REG_AW-1:0] REG_LOADER_END = 8'h0c;
	localparam logic [REG_AW-1:0] REG_CODE_END = 8'h10;
	// Field positions in control_second_register and status.
	localparam int CTRL_LOCK_BIT = 0;
	localparam int CTRL_GUARD_BIT = 1;
	localparam int CTRL_VSEL_BIT = 2;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_ERR_BIT = 1;
	localparam int STAT_LOCKEFF_BIT = 2;
	localparam int STAT_SEC_LSB = 3;
	// Command codes.
	localparam logic [2:0] CMD_NONE = 3'h0;
	localparam logic [2:0] CMD_WRITE = 3'h1;
	localparam logic [2:0] CMD_ERASE = 3'h2;
	localparam logic [2:0] CMD_ERASE_WRITE = 3'h3;
	localparam logic [2:0] CMD_CLEAR_BUF = 3'h4;
	localparam logic [2:0] CMD_CHIP_ERASE = 3'h5;
	localparam logic [2:0] CMD_EE_ERASE = 3'h6;
	typedef enum logic [1:0] {SEC_LOADER, SEC_CODE, SEC_DATA} nsp_sec_t;
	typedef enum logic [1:0] {SP_FLASH, SP_EEPROM, SP_USER_ROW} nsp_space_t;
	typedef enum logic [1:0] {ACC_FETCH, ACC_READ, ACC_WRITE} nsp_acc_t;
endpackage

//--- nsp_protect.sv
// Flash section protection, page buffer and command gate of the NVM controller.
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module nsp_protect import nsp_pkg::*; (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Fuse values, stable from reset.
	input wire logic [7:0] loader_end_fuse,
	input wire logic [7:0] code_end_fuse,
	// Processor access port.
	input wire logic [ADDR_W-1:0] cpu_pc,
	input wire logic cpu_acc,
	input wire nsp_acc_t cpu_kind,
	input wire nsp_space_t cpu_space,
	input wire logic [ADDR_W-1:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	output logic cpu_ack_q,
	output logic cpu_deny_q,
	// Register port.
	input wire logic [REG_AW-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [7:0] reg_rdata_q,
	// Debug programming link.
	input wire logic dbg_locked,
	input wire logic dbg_wr,
	input wire nsp_space_t dbg_space,
	input wire logic [ADDR_W-1:0] dbg_addr,
	input wire logic [7:0] dbg_wdata,
	input wire logic dbg_cmd_go,
	input wire logic [2:0] dbg_cmd,
	// Memory array side.
	output logic nvm_op_q,
	output logic [2:0] nvm_kind_q,
	output nsp_space_t nvm_space_q,
	output logic [PAGE_W-1:0] nvm_page_q,
	output logic [PAGE_BYTES-1:0] nvm_mask_q,
	input wire logic nvm_done,
	input wire logic [OFS_W-1:0] nvm_rd_idx,
	output logic [7:0] nvm_rd_data_q,
	// Vector table base.
	output logic [ADDR_W-1:0] vec_base_q
);

	// Section of a flash block; boundaries belong to the upper section.
	function automatic nsp_sec_t sec_of(input logic [BLK_W-1:0] blk,
		input logic [7:0] le, input logic [7:0] ce);
		logic [7:0] b;
		b = {1'b0, blk};
		if (le == 8'h00) begin
			sec_of = SEC_LOADER; // R2
		end else if (b < le) begin
			sec_of = SEC_LOADER; // R1 R21
		end else if (ce == 8'h00) begin
			sec_of = SEC_CODE; // R3
		end else if (ce <= le) begin
			sec_of = SEC_DATA; // R4
		end else if (b < ce) begin
			sec_of = SEC_CODE; // R5
		end else begin
			sec_of = SEC_DATA; // R5
		end
	endfunction

	logic [7:0] le_q;
	logic [7:0] ce_q;
	logic fuse_taken_q;
	logic lock_q;
	logic guard_q;
	logic vsel_q;
	logic busy_q;
	logic err_q;
	logic op_dbg_q;
	logic [7:0] buf_q [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] mark_q;
	nsp_space_t space_q;
	logic [PAGE_W-1:0] page_q;
	nsp_sec_t exec_sec;
	nsp_sec_t tgt_sec;
	logic lock_eff;
	logic cpu_hit_loader;
	logic dbg_wr_ok;
	logic cpu_wr_ok;
	logic buf_wr;
	logic [OFS_W-1:0] wr_ofs;
	logic [7:0] wr_data;
	logic cmd_go;
	logic cmd_dbg;
	logic [2:0] cmd;
	logic cmd_ok;
	logic cmd_mem;
	logic refused;
	logic clear_buf;

	// Fuses are caught once, on the first edge after reset release.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			le_q <= LOADER_END_DEFAULT;
			ce_q <= CODE_END_DEFAULT;
			fuse_taken_q <= 1'b0;
		end else if (!fuse_taken_q) begin
			fuse_taken_q <= 1'b1;
			le_q <= (loader_end_fuse > LAST_BLOCK) ?
				LOADER_END_DEFAULT : loader_end_fuse; // R6
			ce_q <= (code_end_fuse > LAST_BLOCK) ?
				CODE_END_DEFAULT : code_end_fuse; // R6
		end
	end

	// Section decode of the running code and of the buffered target page.
	always_comb begin
		exec_sec = sec_of(cpu_pc[ADDR_W-1:8], le_q, ce_q);
		tgt_sec = sec_of(page_q[PAGE_W-1:2], le_q, ce_q);
		lock_eff = lock_q && (exec_sec != SEC_LOADER); // R12
		cpu_hit_loader = (cpu_space == SP_FLASH) &&
			(sec_of(cpu_addr[ADDR_W-1:8], le_q, ce_q) == SEC_LOADER);
	end

	// Page buffer writers; the debug link wins a tie, so the core is denied.
	always_comb begin
		dbg_wr_ok = dbg_wr && !busy_q &&
			(!dbg_locked || dbg_space == SP_USER_ROW); // R18
		cpu_wr_ok = cpu_acc && (cpu_kind == ACC_WRITE) && !busy_q && !dbg_wr;
		buf_wr = dbg_wr_ok || cpu_wr_ok;
		wr_ofs = dbg_wr_ok ? dbg_addr[OFS_W-1:0] : cpu_addr[OFS_W-1:0];
		wr_data = dbg_wr_ok ? dbg_wdata : cpu_wdata;
	end

	// Command gate: decides whether the buffered operation may proceed.
	always_comb begin
		cmd_dbg = dbg_cmd_go;
		cmd = dbg_cmd_go ? dbg_cmd : reg_wdata[2:0];
		cmd_go = (dbg_cmd_go || (reg_we && reg_addr == REG_CMD)) &&
			!busy_q && (cmd != CMD_NONE);
		cmd_mem = (cmd != CMD_CLEAR_BUF);
		cmd_ok = 1'b0;
		if (cmd_dbg) begin
			if (cmd == CMD_CHIP_ERASE || cmd == CMD_CLEAR_BUF) begin
				cmd_ok = 1'b1; // R20
			end else begin
				cmd_ok = !dbg_locked ||
					((space_q == SP_USER_ROW) && cmd != CMD_EE_ERASE); // R18
			end
		end else begin
			unique case (cmd)
				CMD_CLEAR_BUF: cmd_ok = 1'b1;
				CMD_CHIP_ERASE: cmd_ok = 1'b0;
				CMD_EE_ERASE: cmd_ok = (exec_sec != SEC_DATA); // R9
				default: begin
					if (space_q != SP_FLASH) begin
						cmd_ok = (exec_sec != SEC_DATA); // R9 R17
					end else if (tgt_sec == SEC_LOADER) begin
						cmd_ok = 1'b0; // R10
					end else if (tgt_sec == SEC_CODE) begin
						cmd_ok = (exec_sec == SEC_LOADER) && !guard_q; // R7 R13
					end else begin
						cmd_ok = (exec_sec != SEC_DATA); // R7 R8 R9
					end
				end
			endcase
		end
		// An erase needs one marked byte to know its page.
		if ((cmd == CMD_ERASE || cmd == CMD_ERASE_WRITE) && (mark_q == '0)) begin
			cmd_ok = 1'b0;
		end
		refused = cmd_go && !cmd_ok; // R22
		clear_buf = (cmd_go && cmd_ok && !cmd_mem) || (busy_q && nvm_done);
	end

	// Page buffer contents and update marks; stores AND into the old byte.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				buf_q[i] <= BUF_ERASED;
			end
			mark_q <= '0;
		end else if (clear_buf) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				buf_q[i] <= BUF_ERASED;
			end
			mark_q <= '0;
		end else if (buf_wr) begin
			buf_q[wr_ofs] <= buf_q[wr_ofs] & wr_data;
			mark_q[wr_ofs] <= 1'b1; // R16
		end
	end

	// Target page and memory space follow the latest buffer store.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			space_q <= SP_FLASH;
			page_q <= '0;
		end else if (buf_wr) begin
			space_q <= dbg_wr_ok ? dbg_space : cpu_space;
			page_q <= dbg_wr_ok ? dbg_addr[ADDR_W-1:OFS_W] :
				cpu_addr[ADDR_W-1:OFS_W];
		end
	end

	// Launch of a memory operation; the array answers with nvm_done.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			nvm_op_q <= 1'b0;
			nvm_kind_q <= CMD_NONE;
			nvm_space_q <= SP_FLASH;
			nvm_page_q <= '0;
			nvm_mask_q <= '0;
			op_dbg_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			nvm_op_q <= cmd_go && cmd_ok && cmd_mem;
			if (cmd_go && cmd_ok && cmd_mem) begin
				busy_q <= 1'b1;
				nvm_kind_q <= cmd;
				op_dbg_q <= cmd_dbg;
				nvm_page_q <= page_q;
				// Chip erase names flash; the array spares the user row.
				nvm_space_q <= (cmd == CMD_CHIP_ERASE) ? SP_FLASH :
					(cmd == CMD_EE_ERASE) ? SP_EEPROM : space_q; // R17
				if (space_q == SP_FLASH || cmd == CMD_CHIP_ERASE ||
					cmd == CMD_EE_ERASE) begin
					nvm_mask_q <= '1; // R14
				end else begin
					nvm_mask_q <= mark_q; // R15
				end
			end else if (busy_q && nvm_done) begin
				busy_q <= 1'b0;
			end
		end
	end

	// Buffer read port for the array, one cycle of latency.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			nvm_rd_data_q <= BUF_ERASED;
		end else begin
			nvm_rd_data_q <= buf_q[nvm_rd_idx];
		end
	end

	// Processor access answers; reads of the array itself happen outside.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cpu_ack_q <= 1'b0;
			cpu_deny_q <= 1'b0;
		end else begin
			cpu_ack_q <= cpu_acc;
			cpu_deny_q <= cpu_acc && (((cpu_kind != ACC_WRITE) &&
				cpu_hit_loader && lock_eff) || // R11
				((cpu_kind == ACC_WRITE) && !cpu_wr_ok));
		end
	end

	// Lock and guard can only be set; reset is the one way back.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lock_q <= 1'b0;
			guard_q <= 1'b0;
			vsel_q <= 1'b0;
		end else if (reg_we && reg_addr == REG_CTRL) begin
			if (reg_wdata[CTRL_LOCK_BIT] && exec_sec == SEC_LOADER) begin
				lock_q <= 1'b1; // R12
			end
			if (reg_wdata[CTRL_GUARD_BIT]) begin
				guard_q <= 1'b1; // R13
			end
			vsel_q <= reg_wdata[CTRL_VSEL_BIT];
		end
	end

	// Sticky refusal flag; a new refusal beats a clear in the same cycle.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			err_q <= 1'b0;
		end else if (refused) begin
			err_q <= 1'b1; // R22
		end else if (reg_we && reg_addr == REG_STATUS &&
			reg_wdata[STAT_ERR_BIT]) begin
			err_q <= 1'b0;
		end
	end

	// Vector base: code section start, or zero when select is set.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			vec_base_q <= '0;
		end else begin
			vec_base_q <= vsel_q ? '0 : {le_q[BLK_W-1:0], 8'h00}; // R19
		end
	end

	// Register read data, one cycle after the strobe; unmapped reads zero.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata_q <= 8'h00;
		end else if (reg_re) begin
			unique case (reg_addr)
				REG_CTRL: reg_rdata_q <= {5'h00, vsel_q, guard_q, lock_q};
				REG_STATUS: reg_rdata_q <= {3'h0, exec_sec, lock_eff,
					err_q, busy_q};
				REG_LOADER_END: reg_rdata_q <= le_q;
				REG_CODE_END: reg_rdata_q <= ce_q;
				default: reg_rdata_q <= 8'h00;
			endcase
		end else begin
			reg_rdata_q <= 8'h00;
		end
	end

	// Checks on the protection behaviour.
	AST_LOADER_NEVER_WRITTEN: assert property (@(posedge clk) // R10
		disable iff (!reset_n)
		(nvm_op_q && !op_dbg_q && nvm_space_q == SP_FLASH &&
		nvm_kind_q != CMD_CHIP_ERASE) |->
		sec_of(nvm_page_q[PAGE_W-1:2], le_q, ce_q) != SEC_LOADER)
		else $error("Processor operation reached the loader section.");
	AST_LOCK_DENY: assert property (@(posedge clk) // R11
		disable iff (!reset_n)
		(cpu_acc && cpu_kind != ACC_WRITE && cpu_hit_loader && lock_eff)
		|=> (cpu_ack_q && cpu_deny_q))
		else $error("Locked loader access was not denied.");
	AST_LOCK_SOURCE: assert property (@(posedge clk) // R12
		disable iff (!reset_n)
		$rose(lock_q) |-> $past(exec_sec) == SEC_LOADER)
		else $error("Loader lock set from outside the loader.");
	AST_GUARD_HOLDS: assert property (@(posedge clk) // R13
		disable iff (!reset_n)
		(guard_q && cmd_go && !cmd_dbg && space_q == SP_FLASH &&
		tgt_sec == SEC_CODE && cmd != CMD_CLEAR_BUF &&
		cmd != CMD_EE_ERASE) |=> !nvm_op_q)
		else $error("Guarded code section was updated.");
	AST_FLASH_WHOLE_PAGE: assert property (@(posedge clk) // R14
		disable iff (!reset_n)
		(nvm_op_q && nvm_space_q == SP_FLASH) |-> (nvm_mask_q == '1))
		else $error("Partial flash page operation.");
	AST_EE_MARKED_ONLY: assert property (@(posedge clk) // R15
		disable iff (!reset_n)
		(nvm_op_q && nvm_space_q != SP_FLASH &&
		nvm_kind_q != CMD_EE_ERASE) |-> (nvm_mask_q == $past(mark_q)))
		else $error("EEPROM mask differs from update marks.");
	AST_MARK_ON_STORE: assert property (@(posedge clk) // R16
		disable iff (!reset_n)
		(buf_wr && !clear_buf) |=> mark_q[$past(wr_ofs)])
		else $error("Stored byte was not marked.");
	AST_DATA_NO_WRITE: assert property (@(posedge clk) // R9
		disable iff (!reset_n)
		(cmd_go && !cmd_dbg && exec_sec == SEC_DATA && cmd_mem) |=>
		(!nvm_op_q ##1 !nvm_op_q))
		else $error("Program data code launched a write.");
	AST_FUSE_DEFAULT: assert property (@(posedge clk) // R6
		disable iff (!reset_n)
		fuse_taken_q |-> (le_q <= LAST_BLOCK && ce_q <= LAST_BLOCK))
		else $error("Out of range fuse value was kept.");
	AST_REFUSE_DISCARD: assert property (@(posedge clk) // R22
		disable iff (!reset_n)
		refused |=> (err_q && !nvm_op_q && !busy_q))
		else $error("Refused command was not discarded.");
	AST_USER_ROW_DBG: assert property (@(posedge clk) // R18
		disable iff (!reset_n)
		(dbg_cmd_go && dbg_locked && !busy_q && cmd == CMD_WRITE &&
		space_q == SP_USER_ROW) |=> (nvm_op_q && nvm_space_q == SP_USER_ROW))
		else $error("Locked device refused a user row write.");
	COV_LOCK_SET: cover property (@(posedge clk) disable iff (!reset_n)
		$rose(lock_q) ##[1:50] lock_eff);
	COV_EE_OP: cover property (@(posedge clk) disable iff (!reset_n)
		nvm_op_q && nvm_space_q == SP_EEPROM);
	COV_REFUSED: cover property (@(posedge clk) disable iff (!reset_n)
		refused && !cmd_dbg);

endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking testbench for the flash section write protection.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import nsp_pkg::*;
	logic clk = 1'h0;
	logic reset_n = 1'h0;
	logic [7:0] loader_end_fuse = 8'h04, code_end_fuse = 8'h08;
	logic [ADDR_W-1:0] cpu_pc = '0, cpu_addr = '0;
	logic cpu_acc = 1'h0;
	nsp_acc_t cpu_kind = ACC_READ;
	nsp_space_t cpu_space = SP_FLASH;
	logic [7:0] cpu_wdata = 8'h00;
	logic cpu_ack_q, cpu_deny_q;
	logic [REG_AW-1:0] reg_addr = '0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_we = 1'h0, reg_re = 1'h0;
	logic [7:0] reg_rdata_q;
	logic dbg_locked = 1'h0, dbg_wr = 1'h0, dbg_cmd_go = 1'h0;
	nsp_space_t dbg_space = SP_FLASH;
	logic [ADDR_W-1:0] dbg_addr = '0;
	logic [7:0] dbg_wdata = 8'h00;
	logic [2:0] dbg_cmd = 3'h0;
	logic nvm_op_q, nvm_done;
	logic [2:0] nvm_kind_q;
	nsp_space_t nvm_space_q;
	logic [PAGE_W-1:0] nvm_page_q;
	logic [PAGE_BYTES-1:0] nvm_mask_q;
	logic [OFS_W-1:0] nvm_rd_idx = '0;
	logic [7:0] nvm_rd_data_q, rd, le;
	logic [ADDR_W-1:0] vec_base_q;
	logic slow = 1'h0;
	int mismatches = 0;
	int checks_done = 0;
	// Fuse pairs, running address and the section expected there.
	logic [7:0] c_le [10] = '{8'h00, 8'h04, 8'h08, 8'h08, 8'h04, 8'h04,
		8'h04, 8'h04, 8'h80, 8'h04};
	logic [7:0] c_ce [10] = '{8'h08, 8'h00, 8'h04, 8'h04, 8'h08, 8'h08,
		8'h08, 8'h08, 8'h04, 8'h90};
	logic [14:0] c_pc [10] = '{15'h7fff, 15'h7fff, 15'h0800, 15'h07ff,
		15'h0800, 15'h07ff, 15'h0400, 15'h03ff, 15'h7fff, 15'h7fff};
	logic [1:0] c_sec [10] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h2, 2'h1, 2'h1,
		2'h0, 2'h0, 2'h1};

	nsp_protect dut_u (.clk, .reset_n, .loader_end_fuse, .code_end_fuse,
		.cpu_pc, .cpu_acc, .cpu_kind, .cpu_space, .cpu_addr, .cpu_wdata,
		.cpu_ack_q, .cpu_deny_q, .reg_addr, .reg_wdata, .reg_we, .reg_re,
		.reg_rdata_q, .dbg_locked, .dbg_wr, .dbg_space, .dbg_addr,
		.dbg_wdata, .dbg_cmd_go, .dbg_cmd, .nvm_op_q, .nvm_kind_q,
		.nvm_space_q, .nvm_page_q, .nvm_mask_q, .nvm_done, .nvm_rd_idx,
		.nvm_rd_data_q, .vec_base_q);
	nsp_array_model array_u (.clk, .reset_n, .op(nvm_op_q), .slow,
		.done_q(nvm_done));

	// Free-running 10 MHz clock.
	always #50 clk = ~clk;

	task automatic check(input string what, input logic [63:0] seen,
		input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Fuses are only taken after reset, so each layout needs a fresh one.
	task automatic rst(input logic [7:0] l, input logic [7:0] c,
		input logic [ADDR_W-1:0] pc);
		@(posedge clk);
		reset_n <= 1'h0;
		loader_end_fuse <= l;
		code_end_fuse <= c;
		cpu_pc <= pc;
		repeat (16) @(posedge clk);
		reset_n <= 1'h1;
		repeat (3) @(posedge clk);
	endtask

	task automatic reg_wr(input logic [REG_AW-1:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_we <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_we <= 1'h0;
	endtask

	task automatic reg_rd(input logic [REG_AW-1:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_re <= 1'h1;
		reg_addr <= a;
		@(posedge clk);
		reg_re <= 1'h0;
		#1;
		d = reg_rdata_q;
	endtask

	task automatic cpu(input nsp_acc_t k, input nsp_space_t s,
		input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic deny);
		@(posedge clk);
		cpu_acc <= 1'h1;
		cpu_kind <= k;
		cpu_space <= s;
		cpu_addr <= a;
		cpu_wdata <= d;
		@(posedge clk);
		cpu_acc <= 1'h0;
		#1;
		check("cpu ack", cpu_ack_q, 1'h1);
		check("cpu deny", cpu_deny_q, deny);
	endtask

	task automatic dbg_st(input nsp_space_t s, input logic [ADDR_W-1:0] a);
		@(posedge clk);
		dbg_wr <= 1'h1;
		dbg_space <= s;
		dbg_addr <= a;
		dbg_wdata <= 8'h55;
		@(posedge clk);
		dbg_wr <= 1'h0;
	endtask

	// A refused command leaves the error flag, which is cleared again here.
	task automatic cmd(input logic dbg, input logic [2:0] c, input logic go);
		int n;
		@(posedge clk);
		if (dbg) begin
			dbg_cmd_go <= 1'h1;
			dbg_cmd <= c;
		end else begin
			reg_we <= 1'h1;
			reg_addr <= REG_CMD;
			reg_wdata <= {5'h00, c};
		end
		@(posedge clk);
		dbg_cmd_go <= 1'h0;
		reg_we <= 1'h0;
		#1;
		check("launch", nvm_op_q, go);
		if (go) begin
			check("kind", nvm_kind_q, c);
			n = 0;
			while (nvm_done !== 1'h1 && n < 100) begin
				@(posedge clk);
				#1;
				n++;
			end
			check("done", nvm_done, 1'h1);
			@(posedge clk);
		end else begin
			reg_rd(REG_STATUS, rd);
			check("refusal", rd[STAT_ERR_BIT], c != CMD_CLEAR_BUF);
			reg_wr(REG_STATUS, 8'h02);
		end
	endtask

	task automatic op_chk(input nsp_space_t s, input logic [PAGE_W-1:0] p,
		input logic [63:0] m);
		check("space", nvm_space_q, s);
		check("page", nvm_page_q, p);
		check("mask", nvm_mask_q, m);
	endtask

	// Main sequence.
	initial begin
		for (int i = 0; i < 10; i++) begin
			rst(c_le[i], c_ce[i], c_pc[i]);
			le = (c_le[i] > LAST_BLOCK) ? LOADER_END_DEFAULT : c_le[i];
			reg_rd(REG_STATUS, rd);
			check("section", rd[STAT_SEC_LSB +: 2], c_sec[i]);
			reg_rd(REG_LOADER_END, rd);
			check("loader end", rd, le);
			check("vectors", vec_base_q, {le[6:0], 8'h00});
		end
		$display("test sections done");
		rst(8'h04, 8'h08, 15'h0100);
		cpu(ACC_WRITE, SP_FLASH, 15'h0400, 8'h5a, 1'h0);
		cmd(1'h0, CMD_ERASE_WRITE, 1'h1);
		op_chk(SP_FLASH, 9'h010, '1);
		slow <= 1'h1;
		cpu(ACC_WRITE, SP_FLASH, 15'h0900, 8'h33, 1'h0);
		cmd(1'h0, CMD_WRITE, 1'h1);
		op_chk(SP_FLASH, 9'h024, '1);
		slow <= 1'h0;
		cpu(ACC_WRITE, SP_FLASH, 15'h0100, 8'h00, 1'h0);
		cmd(1'h0, CMD_WRITE, 1'h0);
		cmd(1'h0, CMD_CLEAR_BUF, 1'h0);
		cpu_pc <= 15'h0500;
		cpu(ACC_WRITE, SP_FLASH, 15'h0900, 8'h00, 1'h0);
		cmd(1'h0, CMD_WRITE, 1'h1);
		cpu(ACC_WRITE, SP_FLASH, 15'h0600, 8'h00, 1'h0);
		cmd(1'h0, CMD_WRITE, 1'h0);
		cmd(1'h0, CMD_CLEAR_BUF, 1'h0);
		cpu_pc <= 15'h0900;
		cpu(ACC_WRITE, SP_FLASH, 15'h0a00, 8'h00, 1'h0);
		cmd(1'h0, CMD_WRITE, 1'h0);
		cpu(ACC_WRITE, SP_EEPROM, 15'h0003, 8'h00, 1'h0);
		cmd(1'h0, CMD_WRITE, 1'h0);
		cmd(1'h0, CMD_EE_ERASE, 1'h0);
		cmd(1'h0, CMD_CLEAR_BUF, 1'h0);
		$display("test section writes done");
		cpu_pc <= 15'h0100;
		cmd(1'h0, CMD_ERASE, 1'h0);
		cpu(ACC_WRITE, SP_EEPROM, 15'h0003, 8'h11, 1'h0);
		cpu(ACC_WRITE, SP_EEPROM, 15'h0005, 8'h22, 1'h0);
		cmd(1'h0, CMD_ERASE, 1'h1);
		op_chk(SP_EEPROM, 9'h000, 64'h28);
		cpu(ACC_WRITE, SP_USER_ROW, 15'h0001, 8'h44, 1'h0);
		cmd(1'h0, CMD_WRITE, 1'h1);
		op_chk(SP_USER_ROW, 9'h000, 64'h2);
		cmd(1'h0, CMD_EE_ERASE, 1'h1);
		op_chk(SP_EEPROM, 9'h000, '1);
		cpu(ACC_WRITE, SP_FLASH, 15'h0400, 8'h5a, 1'h0);
		cpu(ACC_WRITE, SP_FLASH, 15'h0400, 8'h0f, 1'h0);
		@(posedge clk);
		#1;
		check("buffer byte", nvm_rd_data_q, 8'h0a);
		$display("test page buffer done");
		reg_wr(REG_CTRL, 8'h02);
		cmd(1'h0, CMD_WRITE, 1'h0);
		cmd(1'h0, CMD_CLEAR_BUF, 1'h0);
		reg_wr(REG_CTRL, 8'h03);
		reg_rd(REG_CTRL, rd);
		check("lock bit", rd[CTRL_LOCK_BIT], 1'h1);
		reg_rd(REG_STATUS, rd);
		check("lock early", rd[STAT_LOCKEFF_BIT], 1'h0);
		cpu(ACC_READ, SP_FLASH, 15'h0100, 8'h00, 1'h0);
		cpu_pc <= 15'h0500;
		cpu(ACC_FETCH, SP_FLASH, 15'h0100, 8'h00, 1'h1);
		cpu(ACC_READ, SP_FLASH, 15'h03ff, 8'h00, 1'h1);
		cpu(ACC_READ, SP_FLASH, 15'h0400, 8'h00, 1'h0);
		cmd(1'h1, CMD_CHIP_ERASE, 1'h1);
		check("erase mask", nvm_mask_q, '1);
		reg_wr(REG_CTRL, 8'h07);
		repeat (2) @(posedge clk);
		#1;
		check("vectors", vec_base_q, 15'h0000);
		rst(8'h04, 8'h08, 15'h0500);
		reg_wr(REG_CTRL, 8'h01);
		reg_rd(REG_CTRL, rd);
		check("lock bit", rd[CTRL_LOCK_BIT], 1'h0);
		cpu(ACC_FETCH, SP_FLASH, 15'h0100, 8'h00, 1'h0);
		$display("test lock and guard done");
		dbg_locked <= 1'h1;
		dbg_st(SP_USER_ROW, 15'h0002);
		cmd(1'h1, CMD_WRITE, 1'h1);
		op_chk(SP_USER_ROW, 9'h000, 64'h4);
		// The core names a flash page, so the locked link must be refused.
		cpu(ACC_WRITE, SP_FLASH, 15'h0900, 8'hf0, 1'h0);
		dbg_st(SP_FLASH, 15'h0900);
		@(posedge clk);
		#1;
		check("locked store", nvm_rd_data_q, 8'hf0);
		cmd(1'h1, CMD_WRITE, 1'h0);
		$display("test debug link done");
		end_of_test();
	end

	// Watchdog well beyond the few hundred cycles the tests need.
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		end_of_test();
	end
endmodule
`default_nettype wire
